// file: rtl/irm_regs.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - High mask bit k enables channel 32+k
// - Low mask bit k enables channel k
// - High set/clear reads return mask unchanged
// - High mask set at 0x70, clear 0x74
// - Low mask set at 0x78, clear 0x7C
// - Set port: ones set bits, zeros keep
// - Clear port: ones clear bits, zeros keep
module irm_regs
  import irm_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  arst_n_in,
  // AXI4-Lite write address
  input  wire logic [IRM_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [IRM_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [IRM_LANES-1:0]  s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [IRM_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  // AXI4-Lite read data
  output logic [IRM_DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // Isochronous packet side
  input  wire logic                  pkt_valid_in,
  input  wire logic [IRM_CHAN_W-1:0] pkt_chan_in,
  output logic                       pkt_accept_out,
  output logic                       pkt_reject_out
);
  logic                  awready_ff;
  logic                  wready_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  arready_ff;
  logic                  rvalid_ff;
  logic [IRM_DATA_W-1:0] rdata_ff;
  logic [1:0]            rresp_ff;
  logic [IRM_ADDR_W-1:0] awaddr_ff;
  logic [IRM_DATA_W-1:0] wdata_ff;
  logic [IRM_LANES-1:0]  wstrb_ff;
  logic [31:0]           mask_hi_ff;
  logic [31:0]           mask_lo_ff;
  logic [31:0]           nxt_mask_hi;
  logic [31:0]           nxt_mask_lo;
  logic                  wr_fire;
  logic                  ar_fire;
  irm_sel_t              wr_sel;
  irm_sel_t              rd_sel;

  irm_filt_if filt_if ();

  function automatic irm_sel_t decode_sel(input logic [IRM_ADDR_W-1:0] addr);
    irm_sel_t sel;
    sel = IRM_SEL_NONE;
    case (addr)
      IRM_OFS_HI_SET: sel = IRM_SEL_HI_SET;
      IRM_OFS_HI_CLR: sel = IRM_SEL_HI_CLR;
      IRM_OFS_LO_SET: sel = IRM_SEL_LO_SET;
      IRM_OFS_LO_CLR: sel = IRM_SEL_LO_CLR;
      default:        sel = IRM_SEL_NONE;
    endcase
    return sel;
  endfunction : decode_sel

  // Address and data are parked until both have arrived and bvalid is free
  assign wr_fire = ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign ar_fire = s_axi_arvalid_in & arready_ff;
  assign wr_sel  = decode_sel(awaddr_ff);
  assign rd_sel  = decode_sel(s_axi_araddr_in);

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      awready_ff <= 1'b1;
      awaddr_ff  <= '0;
    end
    else if (s_axi_awvalid_in && awready_ff)
    begin
      awready_ff <= 1'b0;
      awaddr_ff  <= s_axi_awaddr_in;
    end
    else if (bvalid_ff && s_axi_bready_in)
    begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wready_ff <= 1'b1;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else if (s_axi_wvalid_in && wready_ff)
    begin
      wready_ff <= 1'b0;
      wdata_ff  <= s_axi_wdata_in;
      wstrb_ff  <= s_axi_wstrb_in;
    end
    else if (bvalid_ff && s_axi_bready_in)
    begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= IRM_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_sel == IRM_SEL_NONE) ? IRM_RESP_SLVERR : IRM_RESP_OKAY;
    end
    else if (s_axi_bready_in)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // Byte lanes without a strobe are left alone
  generate
    for (genvar b = 0; b < IRM_LANES; b++)
    begin : g_lane
      logic [7:0] d;
      logic [7:0] h;
      logic [7:0] l;
      logic       en;
      assign d  = wdata_ff[8*b +: 8];
      assign h  = mask_hi_ff[8*b +: 8];
      assign l  = mask_lo_ff[8*b +: 8];
      assign en = wr_fire & wstrb_ff[b];
      assign nxt_mask_hi[8*b +: 8] =
        (en && wr_sel == IRM_SEL_HI_SET) ? (h | d) :
        (en && wr_sel == IRM_SEL_HI_CLR) ? (h & ~d) :
        h;
      assign nxt_mask_lo[8*b +: 8] =
        (en && wr_sel == IRM_SEL_LO_SET) ? (l | d) :
        (en && wr_sel == IRM_SEL_LO_CLR) ? (l & ~d) :
        l;
    end
  endgenerate

  // Masks are given a known value so no X reaches the filter
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mask_hi_ff <= IRM_MASK_RST;
      mask_lo_ff <= IRM_MASK_RST;
    end
    else
    begin
      mask_hi_ff <= nxt_mask_hi;
      mask_lo_ff <= nxt_mask_lo;
    end
  end

  // Read path: both ports of a mask return the same value, never modified
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= IRM_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= IRM_RESP_OKAY;
      case (rd_sel)
        IRM_SEL_HI_SET, IRM_SEL_HI_CLR: rdata_ff <= mask_hi_ff;
        IRM_SEL_LO_SET, IRM_SEL_LO_CLR: rdata_ff <= mask_lo_ff;
        default:
        begin
          rdata_ff <= '0;
          rresp_ff <= IRM_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready_in)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign filt_if.mask      = {mask_hi_ff, mask_lo_ff};
  assign filt_if.pkt_valid = pkt_valid_in;
  assign filt_if.pkt_chan  = pkt_chan_in;

  irm_chan_filter u_filter (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .filt       (filt_if.filt)
  );

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out  = wready_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;
  assign pkt_accept_out    = filt_if.accept;
  assign pkt_reject_out    = filt_if.reject;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_wr(irm_sel_t s);
    wr_fire && wr_sel == s && wstrb_ff == 4'hF;
  endsequence

  property p_hi_set;
    s_wr(IRM_SEL_HI_SET) |=> ((mask_hi_ff & $past(wdata_ff)) == $past(wdata_ff))
      && (((mask_hi_ff ^ $past(mask_hi_ff)) & ~$past(wdata_ff)) == 32'h0000_0000);
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("high set port wrong");

  property p_lo_set;
    s_wr(IRM_SEL_LO_SET) |=> ((mask_lo_ff & $past(wdata_ff)) == $past(wdata_ff))
      && (mask_hi_ff == $past(mask_hi_ff));
  endproperty
  a_lo_set: assert property (p_lo_set) else $error("low set port wrong");

  property p_hi_clr;
    s_wr(IRM_SEL_HI_CLR) |=> ((mask_hi_ff & $past(wdata_ff)) == 32'h0000_0000)
      && (((mask_hi_ff ^ $past(mask_hi_ff)) & ~$past(wdata_ff)) == 32'h0000_0000);
  endproperty
  a_hi_clr: assert property (p_hi_clr) else $error("high clear port wrong");

  property p_lo_clr;
    s_wr(IRM_SEL_LO_CLR) |=> ((mask_lo_ff & $past(wdata_ff)) == 32'h0000_0000)
      && (mask_hi_ff == $past(mask_hi_ff));
  endproperty
  a_lo_clr: assert property (p_lo_clr) else $error("low clear port wrong");

  property p_rd_hi;
    ar_fire && (s_axi_araddr_in == IRM_OFS_HI_SET || s_axi_araddr_in == IRM_OFS_HI_CLR)
      |=> rvalid_ff && rresp_ff == IRM_RESP_OKAY && rdata_ff == $past(mask_hi_ff);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high mask read wrong");

  property p_rd_lo;
    ar_fire && (s_axi_araddr_in == IRM_OFS_LO_SET || s_axi_araddr_in == IRM_OFS_LO_CLR)
      |=> rvalid_ff && rresp_ff == IRM_RESP_OKAY && rdata_ff == $past(mask_lo_ff);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low mask read wrong");

  property p_rd_keep;
    ar_fire && !wr_fire |=> mask_hi_ff == $past(mask_hi_ff)
      && mask_lo_ff == $past(mask_lo_ff);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read changed a mask");

  property p_map;
    wr_fire && wr_sel != IRM_SEL_NONE |=> bvalid_ff && bresp_ff == IRM_RESP_OKAY;
  endproperty
  a_map: assert property (p_map) else $error("mapped write refused");

  property p_unmapped;
    wr_fire && awaddr_ff != IRM_OFS_HI_SET && awaddr_ff != IRM_OFS_HI_CLR
      && awaddr_ff != IRM_OFS_LO_SET && awaddr_ff != IRM_OFS_LO_CLR
      |=> bvalid_ff && bresp_ff == IRM_RESP_SLVERR
      && mask_hi_ff == $past(mask_hi_ff) && mask_lo_ff == $past(mask_lo_ff);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write acted");

  property p_acc_hi;
    pkt_valid_in && pkt_chan_in[5]
      |=> pkt_accept_out == $past(mask_hi_ff[pkt_chan_in[4:0]])
      && pkt_reject_out == !pkt_accept_out;
  endproperty
  a_acc_hi: assert property (p_acc_hi) else $error("high channel filter wrong");

  property p_acc_lo;
    pkt_valid_in && !pkt_chan_in[5]
      |=> pkt_accept_out == $past(mask_lo_ff[pkt_chan_in[4:0]])
      && pkt_reject_out == !pkt_accept_out;
  endproperty
  a_acc_lo: assert property (p_acc_lo) else $error("low channel filter wrong");

  property p_idle;
    !pkt_valid_in |=> !pkt_accept_out && !pkt_reject_out;
  endproperty
  a_idle: assert property (p_idle) else $error("filter pulse without packet");
endmodule : irm_regs

// file: rtl/irm_pkg.sv
package irm_pkg;
  localparam int unsigned IRM_ADDR_W = 8;
  localparam int unsigned IRM_DATA_W = 32;
  localparam int unsigned IRM_CHAN_W = 6;
  localparam int unsigned IRM_LANES  = 4;

  // Register byte offsets
  localparam logic [7:0] IRM_OFS_HI_SET = 8'h70;
  localparam logic [7:0] IRM_OFS_HI_CLR = 8'h74;
  localparam logic [7:0] IRM_OFS_LO_SET = 8'h78;
  localparam logic [7:0] IRM_OFS_LO_CLR = 8'h7C;

  // Masks power up undefined; we force a known value
  localparam logic [31:0] IRM_MASK_RST = 32'h0000_0000;

  localparam logic [1:0] IRM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IRM_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    IRM_SEL_NONE   = 3'b000,
    IRM_SEL_HI_SET = 3'b001,
    IRM_SEL_HI_CLR = 3'b010,
    IRM_SEL_LO_SET = 3'b011,
    IRM_SEL_LO_CLR = 3'b100
  } irm_sel_t;
endpackage : irm_pkg

// file: rtl/irm_filt_if.sv
`timescale 1ns/10ps
interface irm_filt_if;
  import irm_pkg::*;
  logic [63:0]           mask;
  logic                  pkt_valid;
  logic [IRM_CHAN_W-1:0] pkt_chan;
  logic                  accept;
  logic                  reject;

  modport regs (output mask, output pkt_valid, output pkt_chan,
                input accept, input reject);
  modport filt (input mask, input pkt_valid, input pkt_chan,
                output accept, output reject);
endinterface : irm_filt_if

// file: rtl/irm_chan_filter.sv
`timescale 1ns/10ps
module irm_chan_filter
  import irm_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  // Mask and packet side
  irm_filt_if.filt  filt
);
  logic accept_ff;
  logic reject_ff;
  logic chan_en;

  // Channel 32+k maps to high bit k, channel k to low bit k
  assign chan_en = filt.mask[filt.pkt_chan];

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      accept_ff <= 1'b0;
      reject_ff <= 1'b0;
    end
    else
    begin
      accept_ff <= filt.pkt_valid & chan_en;
      reject_ff <= filt.pkt_valid & ~chan_en;
    end
  end

  assign filt.accept = accept_ff;
  assign filt.reject = reject_ff;
endmodule : irm_chan_filter

// file: test/irm_pkt_src.sv
`timescale 1ns/10ps
module irm_pkt_src
  import irm_pkg::*;
(
  // Clock
  input  wire logic                  clk_in,
  // Bench command
  input  wire logic                  go_in,
  input  wire logic [IRM_CHAN_W-1:0] chan_in,
  // Packet header toward the block
  output logic                       valid_out,
  output logic [IRM_CHAN_W-1:0]      chan_out
);
  // Idle channel lines flip so a stale header can never look valid
  always_ff @(posedge clk_in)
  begin
    valid_out <= go_in;
    chan_out  <= go_in ? chan_in : ~chan_out;
  end
endmodule : irm_pkt_src

// file: test/iso_rx_channel_mask_regs_tb.sv
`timescale 1ns/10ps
module iso_rx_channel_mask_regs_tb;
  import irm_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, acc, rej;
  logic [1:0]  bresp, rresp, r;
  logic        go = 0, pv = 0, chk_on = 0;
  logic [5:0]  chan = 6'h00, pch, pc = 6'h00;
  logic        pvld;
  logic [63:0] mdl = 64'h0;
  logic [31:0] d, bm, got;
  logic [7:0]  a;
  logic [7:0]  tbl [6] = '{IRM_OFS_HI_SET, IRM_OFS_HI_CLR, IRM_OFS_LO_SET, IRM_OFS_LO_CLR,
                           8'h80, 8'h71};
  int          bad_count = 0, n_tests = 0, seed = 32'h2f96, i;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  irm_regs u_dut (.sys_clk_in(clk), .arst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pkt_valid_in(pvld),
    .pkt_chan_in(pch), .pkt_accept_out(acc), .pkt_reject_out(rej));

  irm_pkt_src u_src (.clk_in(clk), .go_in(go), .chan_in(chan), .valid_out(pvld),
    .chan_out(pch));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
    @(posedge clk);
    awaddr <= ad; wdata <= dt; wstrb <= st;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] ad);
    @(posedge clk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        got = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axr

  // Expected word and response from the bench's own copy of both masks
  task automatic exp_rd(input logic [7:0] ad);
    axr(ad);
    if (ad == IRM_OFS_HI_SET || ad == IRM_OFS_HI_CLR || ad == IRM_OFS_LO_SET
        || ad == IRM_OFS_LO_CLR)
    begin
      chk("rdata", ad[3] ? mdl[31:0] : mdl[63:32], got);
      chk("rresp", 32'(IRM_RESP_OKAY), 32'(r));
    end
    else
    begin
      chk("rdata_bad", 32'h0, got);
      chk("rresp_bad", 32'(IRM_RESP_SLVERR), 32'(r));
    end
  endtask : exp_rd

  task automatic do_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
    axw(ad, dt, st);
    bm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & dt;
    if (ad == IRM_OFS_HI_SET) mdl[63:32] = mdl[63:32] | bm;
    if (ad == IRM_OFS_LO_SET) mdl[31:0] = mdl[31:0] | bm;
    if (ad == IRM_OFS_HI_CLR) mdl[63:32] = mdl[63:32] & ~bm;
    if (ad == IRM_OFS_LO_CLR) mdl[31:0] = mdl[31:0] & ~bm;
    chk("bresp", (ad == IRM_OFS_HI_SET || ad == IRM_OFS_HI_CLR || ad == IRM_OFS_LO_SET
                  || ad == IRM_OFS_LO_CLR) ? 32'(IRM_RESP_OKAY) : 32'(IRM_RESP_SLVERR),
        32'(r));
  endtask : do_wr

  // A header taken at one edge must be answered by a pulse at the next
  always @(posedge clk)
  begin
    if (chk_on)
    begin
      chk("accept", pv ? 32'(mdl[pc]) : 32'h0, 32'(acc));
      chk("reject", pv ? 32'(!mdl[pc]) : 32'h0, 32'(rej));
    end
    pv <= pvld;
    pc <= pch;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) exp_rd(tbl[i]);
    // Software initialises every bit before relying on the masks
    do_wr(IRM_OFS_HI_CLR, 32'hFFFF_FFFF, 4'hF);
    do_wr(IRM_OFS_LO_CLR, 32'hFFFF_FFFF, 4'hF);
    for (i = 0; i < 60; i++)
    begin
      a = tbl[$unsigned($random(seed)) % 6];
      d = $random(seed);
      do_wr(a, d, (i < 20) ? 4'hF : 4'($random(seed)));
      exp_rd(tbl[$unsigned($random(seed)) % 6]);
    end
    chk_on = 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      go <= (i < 64) || 1'($random(seed));
      chan <= (i < 64) ? 6'(i) : 6'($random(seed));
    end
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    complete_run;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule : iso_rx_channel_mask_regs_tb
